// ===== rcor_cfg.svh
// Register offsets, field positions and fixed values of the clock offset report
`ifndef RCOR_CFG_SVH
`define RCOR_CFG_SVH
`define RCOR_ADDR_INTERVAL   6'h13
`define RCOR_ADDR_OFFSET     6'h14
`define RCOR_IVL_PRF16       32'h01f00000
`define RCOR_IVL_PRF64       32'h01fc0000
`define RCOR_TOFS_W          19
`define RCOR_RSMP_LSB        24
`define RCOR_PHASE_W         7
`define RCOR_OCTET4_LSB      32
`define RCOR_RSMP_W          8
`define RCOR_IVL_W           32
`define RCOR_RD_W            40
`define RCOR_IVL_PAD         8'h00
`define RCOR_IVL_RST         32'h00000000
`define RCOR_OFS_RST         40'h0000000000
`define RCOR_UNMAPPED        40'h0000000000
`define RCOR_BUF0            1'b0
`define RCOR_BUF1            1'b1
`endif

// ===== rcor_pkg.sv
// Types of the clock offset report register bank
package rcor_pkg;
	typedef struct packed {
		logic        prf64;
		logic [18:0] timing_offset_value;
		logic [7:0]  resampler_delay;
		logic [6:0]  carrier_phase_at_stamp;
	} rcor_meas_t;
	typedef struct packed {
		logic [31:0] tracking_interval_value;
		logic [39:0] offset_word;
	} rcor_regs_t;
endpackage

// ===== rcor_bank.sv
// Receive clock offset report registers, double-buffered
`timescale 1ns/1ps
`include "rcor_cfg.svh"
// Function
// - Interval and offset update only on successful frame demodulation.
// - Both registers live in the double-buffered receive set, per buffer.
// - Interval is 0x01F00000 at 16 MHz PRF, 0x01FC0000 at 64 MHz.
// - Interval is the span over which the offset was accumulated.
// - Timing offset is a 19-bit signed value in bits 18..0.
// - Positive offset means remote clock faster; negative means slower.
// - Bits 31..24 report the 8-bit resampler delay, diagnostic only.
// - Octet 4 bits 6..0 hold carrier phase at timestamp capture.
// - Full seven-bit phase range spans 360 degrees of carrier loop.
module rcor_bank import rcor_pkg::*; (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        demod_ok,
	input  wire rcor_meas_t  meas,
	input  wire logic        fill_buf,
	input  wire logic        host_buf,
	input  wire logic        rd_en,
	input  wire logic [5:0]  rd_addr,
	output logic [39:0]      rd_data,
	output logic             rd_valid
);
	// Buffer 0 of the swinging set
	logic [`RCOR_IVL_W-1:0] ivl0_q;
	logic [`RCOR_IVL_W-1:0] ivl0_d;
	logic [`RCOR_RD_W-1:0]  ofs0_q;
	logic [`RCOR_RD_W-1:0]  ofs0_d;
	// Buffer 1 of the swinging set
	logic [`RCOR_IVL_W-1:0] ivl1_q;
	logic [`RCOR_IVL_W-1:0] ivl1_d;
	logic [`RCOR_RD_W-1:0]  ofs1_q;
	logic [`RCOR_RD_W-1:0]  ofs1_d;
	logic [`RCOR_IVL_W-1:0] cap_ivl;
	logic [`RCOR_RD_W-1:0]  cap_ofs;
	logic                   cap0;
	logic                   cap1;
	rcor_regs_t             host_view;
	logic [`RCOR_RD_W-1:0]  rd_data_q;
	logic [`RCOR_RD_W-1:0]  rd_data_d;
	logic                   rd_valid_q;
	logic                   rd_valid_d;

	function automatic logic [`RCOR_IVL_W-1:0] rcor_interval(input logic prf64);
		logic [`RCOR_IVL_W-1:0] v;
		if (prf64) begin
			v = `RCOR_IVL_PRF64;
		end else begin
			v = `RCOR_IVL_PRF16;
		end
		return v;
	endfunction

	function automatic logic [`RCOR_RD_W-1:0] rcor_pack(input rcor_meas_t m);
		logic [`RCOR_RD_W-1:0] w;
		// Reserved positions stay zero
		w = '0;
		w[`RCOR_TOFS_W-1:0] = m.timing_offset_value;
		w[`RCOR_RSMP_LSB +: `RCOR_RSMP_W] = m.resampler_delay;
		w[`RCOR_OCTET4_LSB +: `RCOR_PHASE_W] = m.carrier_phase_at_stamp;
		return w;
	endfunction

	function automatic logic rcor_mapped(input logic [5:0] addr);
		logic hit;
		hit = 1'b0;
		if (addr == `RCOR_ADDR_INTERVAL) begin
			hit = 1'b1;
		end
		if (addr == `RCOR_ADDR_OFFSET) begin
			hit = 1'b1;
		end
		return hit;
	endfunction

	function automatic logic [`RCOR_RD_W-1:0] rcor_read(
		input rcor_regs_t r,
		input logic [5:0] addr
	);
		logic [`RCOR_RD_W-1:0] w;
		w = `RCOR_UNMAPPED;
		unique case (addr)
			`RCOR_ADDR_INTERVAL: begin
				w = {`RCOR_IVL_PAD, r.tracking_interval_value};
			end
			`RCOR_ADDR_OFFSET: begin
				w = r.offset_word;
			end
			default: begin
				w = `RCOR_UNMAPPED;
			end
		endcase
		return w;
	endfunction

	always_comb begin
		cap0    = 1'b0;
		cap1    = 1'b0;
		cap_ivl = rcor_interval(meas.prf64);
		cap_ofs = rcor_pack(meas);
		if (demod_ok) begin
			if (fill_buf == `RCOR_BUF0) begin
				cap0 = 1'b1;
			end else begin
				cap1 = 1'b1;
			end
		end
	end

	// Interval and offset share one strobe, so they always pair
	always_comb begin
		ivl0_d = ivl0_q;
		if (cap0) begin
			ivl0_d = cap_ivl;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ivl0_q <= `RCOR_IVL_RST;
		end else begin
			ivl0_q <= ivl0_d;
		end
	end

	always_comb begin
		ofs0_d = ofs0_q;
		if (cap0) begin
			ofs0_d = cap_ofs;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ofs0_q <= `RCOR_OFS_RST;
		end else begin
			ofs0_q <= ofs0_d;
		end
	end

	always_comb begin
		ivl1_d = ivl1_q;
		if (cap1) begin
			ivl1_d = cap_ivl;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ivl1_q <= `RCOR_IVL_RST;
		end else begin
			ivl1_q <= ivl1_d;
		end
	end

	always_comb begin
		ofs1_d = ofs1_q;
		if (cap1) begin
			ofs1_d = cap_ofs;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ofs1_q <= `RCOR_OFS_RST;
		end else begin
			ofs1_q <= ofs1_d;
		end
	end

	// Host sees the buffer host_buf selects, even when it is the one being filled
	always_comb begin
		host_view.tracking_interval_value = ivl0_q;
		host_view.offset_word             = ofs0_q;
		if (host_buf == `RCOR_BUF1) begin
			host_view.tracking_interval_value = ivl1_q;
			host_view.offset_word             = ofs1_q;
		end
	end

	always_comb begin
		rd_data_d = rd_data_q;
		if (rd_en) begin
			if (rcor_mapped(rd_addr)) begin
				rd_data_d = rcor_read(host_view, rd_addr);
			end else begin
				rd_data_d = `RCOR_UNMAPPED;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_q <= `RCOR_UNMAPPED;
		end else begin
			rd_data_q <= rd_data_d;
		end
	end

	always_comb begin
		rd_valid_d = rd_en;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= rd_valid_d;
		end
	end

	assign rd_data  = rd_data_q;
	assign rd_valid = rd_valid_q;
endmodule

// ===== rcor_bank_monitor.sv
// Read port checker of the report bank
`timescale 1ns/1ps
module rcor_mon (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        rd_en,
	input wire logic        rd_valid,
	input wire logic [5:0]  rd_addr,
	input wire logic [39:0] rd_data
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	valid_one_a: assert property (rd_valid == $past(rd_en))
		else $error("read valid not one cycle after strobe");
	gap_zero_a: assert property (rd_en && !(rd_addr inside {6'h13, 6'h14})
		|=> rd_data == 40'h0000000000)
		else $error("unmapped read not zero");
	rsv_zero_a: assert property (rd_en && rd_addr == 6'h14
		|=> rd_data[23:19] == 5'h00 && rd_data[39] == 1'b0)
		else $error("reserved offset bits not zero");
	ivl_set_a: assert property (rd_en && rd_addr == 6'h13
		|=> rd_data[31:0] inside {32'h00000000, 32'h01f00000, 32'h01fc0000})
		else $error("interval value not allowed");
	ivl_pad_a: assert property (rd_en && rd_addr == 6'h13 |=> rd_data[39:32] == 8'h00)
		else $error("interval upper byte not zero");
	data_hold_a: assert property (!rd_en |=> $stable(rd_data))
		else $error("read data changed without read");
	c_ivl64: cover property (rd_valid && rd_data == 40'h00_01fc0000);
	c_ivl16: cover property (rd_valid && rd_data == 40'h00_01f00000);
	c_neg_ofs: cover property (rd_valid && $past(rd_addr) == 6'h14 && rd_data[18]);
endmodule
bind rcor_bank rcor_mon rcor_mon_i(.*);

// ===== rcor_far.sv
// Remote transmitter model
`timescale 1ns/1ps
module rcor_far import rcor_pkg::*; (input wire logic clk, output logic ok = 0,
	output rcor_meas_t m = '0);
	task frame(input rcor_meas_t x);
		@(posedge clk) begin ok <= 1; m <= x; end
		@(posedge clk) ok <= 0;
	endtask
endmodule

// ===== rcor_bank_tb.sv
// Bench of the report bank
`timescale 1ns/1ps
module rcor_bank_tb import rcor_pkg::*;;
logic clk = 0, rst_n = 0, fb = 0, hb = 0, en = 0, v, dk;
logic [5:0] a = 0;
logic [39:0] d;
rcor_meas_t m;
int n_fail = 0, compares = 0;
always #5 clk = ~clk;
rcor_far rcor_far_i(.clk(clk), .ok(dk), .m(m));
rcor_bank rcor_bank_i(.clk(clk), .rst_n(rst_n), .demod_ok(dk), .meas(m), .fill_buf(fb),
	.host_buf(hb), .rd_en(en), .rd_addr(a), .rd_data(d), .rd_valid(v));
task chk(input logic [39:0] s, e);
	compares++;
	if (s !== e) begin
		n_fail++;
		$display("wrong value at %0t: saw %h expected %h", $time, s, e);
	end
endtask
task rd(input logic [5:0] x, input logic [39:0] e);
	@(posedge clk) begin en <= 1; a <= x; end
	@(posedge clk) en <= 0;
	#1 chk(v, 1);
	chk(d, e);
endtask
task tally_and_finish;
	$display("fails %0d of %0d", n_fail, compares);
	if (n_fail == 0 && compares > 0) $display("STATUS OK");
	else $display("STATUS NOT OK");
	$finish;
endtask
initial begin
	repeat (10) @(posedge clk);
	rst_n <= 1;
	rd(6'h13, 0);
	rcor_far_i.frame({1'b0, 19'h000e4, 8'h5a, 7'h7f});
	rd(6'h13, 40'h01f00000);
	rd(6'h14, 40'h7f5a0000e4);
	chk(d[18], 1'b0);
	@(posedge clk) fb <= 1;
	rcor_far_i.frame({1'b1, 19'h7ff5c, 8'h01, 7'h00});
	rd(6'h14, 40'h7f5a0000e4);
	@(posedge clk) hb <= 1;
	rd(6'h13, 40'h01fc0000);
	rd(6'h14, 40'h000107ff5c);
	chk(d[18], 1'b1);
	rd(6'h2a, 0);
	tally_and_finish();
end
endmodule
